/* perfmon_gating_pkg.sv */
// Constants and types for the enclave performance-monitoring gating block.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
// Operation
// (RULE_01) Status bit 60 flags that counters may be distorted by enclave protection.
// (RULE_02) Opt-in entry leaves counting and sampling untouched; flag stays clear.
// (RULE_03) Opt-out entry suppresses thread monitoring and sets the flag; fixed one, two exempt.
// (RULE_04) Opt-out entry stops fixed counter zero and general counters until exit.
// (RULE_05) No sampling records for this thread while inside an opt-out enclave.
// (RULE_06) Opt-out enclave on one thread demotes sibling all-thread counters to own thread.
// (RULE_07) Normal or asynchronous exit resumes every suppressed activity, sampling included.
// (RULE_08) On exit, demoted sibling counters return to all-thread counting.
// (RULE_09) Supervisor leaves, key and report leaves report their own address.
// (RULE_10) Opt-in entry or resume reports own address; opt-out gives no record.
// (RULE_11) Pending sample at exit: exit address (opt-in) or last entry address (opt-out).
// (RULE_12) Pending sample after async exit: saved-state pointer or last entry address.
// (RULE_13) Sample taken after exiting-event delivery reports the async landing address.
// (RULE_14) Buffer store faults at async exit are dropped and the record is aborted.
// (RULE_15) Buffer store traps are held until the next instruction boundary.
// (RULE_16) After aborting the record, delivery of the exiting event proceeds.
// (RULE_17) Opt-in entry, resume, exit, async exit each count one branch and instruction.
// (RULE_18) Opt-out enclave execution counts as exactly one branch and one instruction.
// (RULE_19) Counters shared between cores are not affected by enclave entry.
// (RULE_20) Per thread, hold opt-out flag and last entry address from entry to exit.
package perfmon_gating_pkg;

    // Counter enable vector: fixed zero, fixed one, fixed two, four general counters
    localparam int NUM_CTR = 7;
    localparam int CTR_FIXED0 = 0;
    localparam int CTR_FIXED1 = 1;
    localparam int CTR_FIXED2 = 2;
    localparam logic [NUM_CTR-1:0] SUPPRESS_MASK = 7'h79;
    localparam int IP_W = 64;

    // Register byte offsets
    localparam logic [7:0] OFF_STATUS_LO = 8'h00;
    localparam logic [7:0] OFF_STATUS_HI = 8'h04;
    localparam logic [7:0] OFF_CTR_EN = 8'h08;
    localparam logic [7:0] OFF_ALL_THREAD = 8'h0C;
    localparam logic [7:0] OFF_MISC = 8'h10;
    localparam logic [7:0] OFF_ENTRY_IP_LO = 8'h14;
    localparam logic [7:0] OFF_ENTRY_IP_HI = 8'h18;

    // Flag is bit 60 of the 64-bit status: bit 28 of the high word
    localparam int FLAG_BIT = 60;
    localparam int FLAG_HI_BIT = FLAG_BIT - 32;
    // Misc control bits
    localparam int MISC_SAMPLE_EN = 0;
    localparam int MISC_SHARED_EN = 1;

    // Reset values
    localparam logic [NUM_CTR-1:0] CTR_EN_RST = 7'h00;
    localparam logic [NUM_CTR-1:0] ALL_THREAD_RST = 7'h00;
    localparam logic [1:0] MISC_RST = 2'h0;

    // Retiring enclave instruction kinds
    typedef enum logic [2:0] {
        LEAF_SUPERVISOR,
        LEAF_KEY,
        LEAF_REPORT,
        LEAF_ENTER,
        LEAF_RESUME,
        LEAF_EXIT,
        LEAF_OTHER_USER
    } leaf_kind_t;

    typedef enum logic [1:0] {
        AX_IDLE,
        AX_RECORD,
        AX_DELIVER
    } aex_state_t;

endpackage

/* enclave_perfmon_gating.sv */
// Enclave-aware gating of counters, sampling and branch/instruction counting for one thread.
// Assumes the core presents one-cycle event pulses synchronous to clk_i and keeps its own counters.
`timescale 1ns/1ps
module enclave_perfmon_gating
    import perfmon_gating_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Enclave instruction retirement
    input wire logic leaf_retire_i,
    input wire leaf_kind_t leaf_kind_i,
    input wire logic [IP_W-1:0] leaf_ip_i,
    input wire logic opt_out_entry_i,
    // Asynchronous exit and exiting-event delivery
    input wire logic async_exit_i,
    input wire logic [IP_W-1:0] saved_state_ip_i,
    input wire logic [IP_W-1:0] landing_ip_i,
    input wire logic eee_done_i,
    input wire logic sample_pending_i,
    input wire logic record_done_i,
    input wire logic store_fault_i,
    input wire logic store_trap_i,
    input wire logic insn_boundary_i,
    input wire logic sibling_opt_out_i,
    // Gating outputs
    output logic [NUM_CTR-1:0] count_en_o,
    output logic [NUM_CTR-1:0] all_thread_o,
    output logic shared_count_en_o,
    output logic demote_sibling_o,
    output logic sample_req_o,
    output logic [IP_W-1:0] eventing_ip_o,
    output logic record_abort_o,
    output logic eee_deliver_o,
    output logic trap_service_o,
    output logic branch_inc_o,
    output logic insn_inc_o
);

    logic in_enclave_ff;
    logic opt_out_ff;
    logic [IP_W-1:0] entry_ip_ff;
    logic flag_ff;
    logic [NUM_CTR-1:0] ctr_en_ff;
    logic [NUM_CTR-1:0] all_thread_ff;
    logic [1:0] misc_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [NUM_CTR-1:0] count_en_ff;
    logic [NUM_CTR-1:0] all_thread_out_ff;
    logic shared_en_ff;
    logic demote_ff;
    logic sample_req_ff;
    logic [IP_W-1:0] eventing_ip_ff;
    logic abort_ff;
    logic deliver_ff;
    logic trap_pend_ff;
    logic trap_service_ff;
    logic branch_inc_ff;
    logic insn_inc_ff;
    aex_state_t ax_state_ff;

    logic is_entry;
    logic is_exit;
    logic wr_en;
    logic flag_clr;
    logic sample_ok;

    assign is_entry = leaf_retire_i && (leaf_kind_i == LEAF_ENTER || leaf_kind_i == LEAF_RESUME);
    assign is_exit = leaf_retire_i && (leaf_kind_i == LEAF_EXIT);
    // Write lands at the access edge where pready is seen high, never in setup
    assign wr_en = psel_i && penable_i && pready_ff && pwrite_i;
    assign flag_clr = wr_en && paddr_i == OFF_STATUS_HI && pwdata_i[FLAG_HI_BIT];
    // Sampling globally enabled and pending
    assign sample_ok = misc_ff[MISC_SAMPLE_EN] && sample_pending_i;

    // Enclave residency tracking
    // (RULE_20) entry state hold
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_enclave_ff <= 1'b0;
            opt_out_ff <= 1'b0;
            entry_ip_ff <= '0;
        end else if (is_entry) begin
            in_enclave_ff <= 1'b1;
            opt_out_ff <= opt_out_entry_i;
            entry_ip_ff <= leaf_ip_i;
        end else if (is_exit || async_exit_i) begin
            // (RULE_07) unsuppress on exit
            in_enclave_ff <= 1'b0;
            opt_out_ff <= 1'b0;
        end
    end

    // Side-channel flag: sticky, write one to clear; a new opt-out entry wins over the clear
    // (RULE_03) flag set opt-out
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_ff <= 1'b0;
        end else if (is_entry && opt_out_entry_i) begin
            flag_ff <= 1'b1;
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end

    // Software control registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctr_en_ff <= CTR_EN_RST;
            all_thread_ff <= ALL_THREAD_RST;
            misc_ff <= MISC_RST;
        end else if (wr_en) begin
            if (paddr_i == OFF_CTR_EN) begin
                ctr_en_ff <= pwdata_i[NUM_CTR-1:0];
            end
            if (paddr_i == OFF_ALL_THREAD) begin
                all_thread_ff <= pwdata_i[NUM_CTR-1:0];
            end
            if (paddr_i == OFF_MISC) begin
                misc_ff <= pwdata_i[1:0];
            end
        end
    end

    // APB answer: data is latched in the setup cycle so pready can sit high
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= 1'b1;
            if (psel_i && !penable_i) begin
                prdata_ff <= 32'h0000_0000;
                pslverr_ff <= 1'b0;
                unique case (paddr_i)
                    OFF_STATUS_LO: prdata_ff <= 32'h0000_0000;
                    // (RULE_01) flag at bit 60
                    OFF_STATUS_HI: prdata_ff <= {3'h0, flag_ff, 28'h000_0000};
                    OFF_CTR_EN: prdata_ff <= {25'h000_0000, ctr_en_ff};
                    OFF_ALL_THREAD: prdata_ff <= {25'h000_0000, all_thread_ff};
                    OFF_MISC: prdata_ff <= {28'h000_0000, opt_out_ff, in_enclave_ff, misc_ff};
                    OFF_ENTRY_IP_LO: prdata_ff <= entry_ip_ff[31:0];
                    OFF_ENTRY_IP_HI: prdata_ff <= entry_ip_ff[63:32];
                    default: pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    // Counter gating; one cycle behind residency by design of registered outputs
    // (RULE_04) stop fixed zero, general
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_en_ff <= '0;
            shared_en_ff <= 1'b0;
        end else begin
            // (RULE_02) opt-in passes all
            count_en_ff <= opt_out_ff ? (ctr_en_ff & ~SUPPRESS_MASK) : ctr_en_ff;
            // (RULE_19) shared counters untouched
            shared_en_ff <= misc_ff[MISC_SHARED_EN];
        end
    end

    // All-thread demotion: ours follows the sibling, sibling's follows us
    // (RULE_06) demote sibling all-thread
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            all_thread_out_ff <= '0;
            demote_ff <= 1'b0;
        end else begin
            // (RULE_08) restore after exit
            all_thread_out_ff <= sibling_opt_out_i ? '0 : all_thread_ff;
            demote_ff <= opt_out_ff;
        end
    end

    // Branch and instruction counting of enclave transitions
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            branch_inc_ff <= 1'b0;
            insn_inc_ff <= 1'b0;
        end else begin
            // (RULE_17) opt-in each transition
            // (RULE_18) opt-out once at exit
            branch_inc_ff <= (is_entry && !opt_out_entry_i) || ((is_exit || async_exit_i) && in_enclave_ff);
            insn_inc_ff <= (is_entry && !opt_out_entry_i) || ((is_exit || async_exit_i) && in_enclave_ff);
        end
    end

    // Asynchronous exit: record, possible abort, then exiting-event delivery
    // (RULE_16) deliver after abort
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ax_state_ff <= AX_IDLE;
            abort_ff <= 1'b0;
            deliver_ff <= 1'b0;
        end else begin
            abort_ff <= 1'b0;
            deliver_ff <= 1'b0;
            unique case (ax_state_ff)
                AX_IDLE: begin
                    if (async_exit_i) begin
                        ax_state_ff <= sample_ok ? AX_RECORD : AX_DELIVER;
                    end
                end
                AX_RECORD: begin
                    // (RULE_14) fault aborts record
                    if (store_fault_i) begin
                        abort_ff <= 1'b1;
                        ax_state_ff <= AX_DELIVER;
                    end else if (record_done_i) begin
                        ax_state_ff <= AX_DELIVER;
                    end
                end
                AX_DELIVER: begin
                    deliver_ff <= 1'b1;
                    ax_state_ff <= AX_IDLE;
                end
            endcase
        end
    end

    // Store traps wait for an instruction boundary; a new trap beats the clear of the pending trap
    // (RULE_15) trap held to boundary
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trap_pend_ff <= 1'b0;
            trap_service_ff <= 1'b0;
        end else begin
            trap_service_ff <= trap_pend_ff && insn_boundary_i;
            if (ax_state_ff == AX_RECORD && store_trap_i) begin
                trap_pend_ff <= 1'b1;
            end else if (insn_boundary_i) begin
                trap_pend_ff <= 1'b0;
            end
        end
    end

    // Sampling request and eventing pointer choice
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_req_ff <= 1'b0;
            eventing_ip_ff <= '0;
        end else begin
            sample_req_ff <= 1'b0;
            if (async_exit_i && sample_ok) begin
                // (RULE_12) async exit pointer
                sample_req_ff <= 1'b1;
                eventing_ip_ff <= opt_out_ff ? entry_ip_ff : saved_state_ip_i;
            end else if (eee_done_i && sample_ok) begin
                // (RULE_13) landing address
                sample_req_ff <= 1'b1;
                eventing_ip_ff <= landing_ip_i;
            end else if (leaf_retire_i && sample_ok) begin
                unique case (leaf_kind_i)
                    LEAF_ENTER, LEAF_RESUME: begin
                        // (RULE_10) opt-out entry silent
                        sample_req_ff <= !opt_out_entry_i;
                        eventing_ip_ff <= leaf_ip_i;
                    end
                    LEAF_EXIT: begin
                        // (RULE_11) exit pointer choice
                        sample_req_ff <= 1'b1;
                        eventing_ip_ff <= opt_out_ff ? entry_ip_ff : leaf_ip_i;
                    end
                    default: begin
                        // (RULE_09) own leaf address
                        // (RULE_05) suppressed in opt-out
                        sample_req_ff <= !opt_out_ff;
                        eventing_ip_ff <= leaf_ip_i;
                    end
                endcase
            end
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign count_en_o = count_en_ff;
    assign all_thread_o = all_thread_out_ff;
    assign shared_count_en_o = shared_en_ff;
    assign demote_sibling_o = demote_ff;
    assign sample_req_o = sample_req_ff;
    assign eventing_ip_o = eventing_ip_ff;
    assign record_abort_o = abort_ff;
    assign eee_deliver_o = deliver_ff;
    assign trap_service_o = trap_service_ff;
    assign branch_inc_o = branch_inc_ff;
    assign insn_inc_o = insn_inc_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Checks on the gating behaviour
    chk_flag_on_optout: assert property (is_entry && opt_out_entry_i |=> flag_ff) // RULE_03
        else $error("flag not set after opt-out entry");
    chk_optin_no_flag: assert property (is_entry && !opt_out_entry_i && !flag_ff && !flag_clr |=> !flag_ff) // RULE_02
        else $error("flag set by opt-in entry");
    chk_fixed0_stops: assert property (opt_out_ff && $past(opt_out_ff) |-> !count_en_o[CTR_FIXED0]) // RULE_04
        else $error("fixed counter zero runs in opt-out enclave");
    chk_cycle_exempt: assert property (##1 count_en_o[CTR_FIXED1] == $past(ctr_en_ff[CTR_FIXED1])) // RULE_03
        else $error("fixed cycle counter one gated");
    chk_no_sample_optout: assert property (opt_out_ff && leaf_retire_i && leaf_kind_i == LEAF_SUPERVISOR
        |=> !sample_req_o) // RULE_05
        else $error("sample emitted inside opt-out enclave");
    chk_resume_after_exit: assert property ((is_exit || async_exit_i) ##1 !is_entry[*2]
        |-> count_en_o == $past(ctr_en_ff)) // RULE_07
        else $error("counters still suppressed after exit");
    chk_demote_sibling: assert property (is_entry && opt_out_entry_i |=> ##1 demote_sibling_o) // RULE_06
        else $error("sibling not demoted");
    chk_exit_ip_optout: assert property (is_exit && opt_out_ff && sample_ok
        |=> sample_req_o && eventing_ip_o == $past(entry_ip_ff)) // RULE_11
        else $error("wrong eventing pointer on opt-out exit");
    chk_abort_deliver: assert property (ax_state_ff == AX_RECORD && store_fault_i
        |=> record_abort_o ##1 eee_deliver_o) // RULE_16
        else $error("exiting event not delivered after abort");
    chk_optout_one_branch: assert property (is_entry && opt_out_entry_i |=> !branch_inc_o) // RULE_18
        else $error("opt-out entry counted as branch");
    chk_trap_wait: assert property (trap_service_o |-> $past(trap_pend_ff) && $past(insn_boundary_i)) // RULE_15
        else $error("trap serviced off a boundary");

endmodule

/* core_event_partner.sv */
// Core-side partner model: counts gated increments and answers sampling buffer stores.
// Assumes one clock shared with the gating block; the store answer comes DLY cycles after a request.
`timescale 1ns/1ps
module core_event_partner #(
    parameter int DLY = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sample_req_i,
    input wire logic branch_inc_i,
    input wire logic insn_inc_i,
    input wire logic [1:0] mode_i,
    output logic record_done_o,
    output logic store_fault_o,
    output logic store_trap_o,
    output int branch_cnt_o,
    output int insn_cnt_o
);
    int wait_ff;
    logic busy_ff;

    // Core counters, advanced only by the gated pulses
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            branch_cnt_o <= 0;
            insn_cnt_o <= 0;
        end else begin
            branch_cnt_o <= branch_cnt_o + int'(branch_inc_i);
            insn_cnt_o <= insn_cnt_o + int'(insn_inc_i);
        end
    end

    // Store answer: mode 1 completes, 2 faults, 3 traps and then completes
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_ff <= 1'b0;
            wait_ff <= 0;
            record_done_o <= 1'b0;
            store_fault_o <= 1'b0;
            store_trap_o <= 1'b0;
        end else if (!busy_ff) begin
            record_done_o <= 1'b0;
            store_fault_o <= 1'b0;
            store_trap_o <= 1'b0;
            busy_ff <= sample_req_i && mode_i != 2'h0;
            wait_ff <= DLY;
        end else begin
            wait_ff <= wait_ff - 1;
            busy_ff <= (wait_ff != 0);
            record_done_o <= (wait_ff == 1 && mode_i == 2'h1) || (wait_ff == 0 && mode_i == 2'h3);
            store_fault_o <= (wait_ff == 1 && mode_i == 2'h2);
            store_trap_o <= (wait_ff == 1 && mode_i == 2'h3);
        end
    end
endmodule

/* tb_top.sv */
// Self-checking bench for the enclave performance-monitoring gating block.
// Assumes a 10 MHz clock, an APB master task and the core partner model for store answers.
`timescale 1ns/1ps
module tb_top;
    import perfmon_gating_pkg::*;
    logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic leaf_retire_i, opt_out_entry_i, async_exit_i, eee_done_i, sample_pending_i;
    leaf_kind_t leaf_kind_i;
    logic [IP_W-1:0] leaf_ip_i, saved_state_ip_i, landing_ip_i, eventing_ip_o;
    logic record_done_i, store_fault_i, store_trap_i, insn_boundary_i, sibling_opt_out_i;
    logic [NUM_CTR-1:0] count_en_o, all_thread_o;
    logic shared_count_en_o, demote_sibling_o, sample_req_o, record_abort_o, eee_deliver_o;
    logic trap_service_o, branch_inc_o, insn_inc_o;
    logic [1:0] mode;
    int branch_cnt, insn_cnt, miscompares, checked, cycles, n_abort, n_trap, b0, i0, t0;

    enclave_perfmon_gating dut_u (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .leaf_retire_i, .leaf_kind_i, .leaf_ip_i,
        .opt_out_entry_i, .async_exit_i, .saved_state_ip_i, .landing_ip_i, .eee_done_i,
        .sample_pending_i, .record_done_i, .store_fault_i, .store_trap_i, .insn_boundary_i,
        .sibling_opt_out_i, .count_en_o, .all_thread_o, .shared_count_en_o, .demote_sibling_o,
        .sample_req_o, .eventing_ip_o, .record_abort_o, .eee_deliver_o, .trap_service_o,
        .branch_inc_o, .insn_inc_o);
    core_event_partner #(.DLY(2)) partner_u (.clk_i, .rst_b_i, .sample_req_i(sample_req_o),
        .branch_inc_i(branch_inc_o), .insn_inc_i(insn_inc_o), .mode_i(mode),
        .record_done_o(record_done_i), .store_fault_o(store_fault_i), .store_trap_o(store_trap_i),
        .branch_cnt_o(branch_cnt), .insn_cnt_o(insn_cnt));

    // Clock, 100 ns period
    always #50 clk_i = ~clk_i;

    // Pulse tallies and hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (record_abort_o === 1'b1) n_abort <= n_abort + 1;
        if (trap_service_o === 1'b1) n_trap <= n_trap + 1;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, takes data at that edge only
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // No wait-state count assumed; only the bench timeout ends a hang
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic leaf(input leaf_kind_t k, input logic [63:0] ip, input logic oo);
        @(posedge clk_i);
        leaf_retire_i <= 1'b1;
        leaf_kind_i <= k;
        leaf_ip_i <= ip;
        opt_out_entry_i <= oo;
        @(posedge clk_i);
        leaf_retire_i <= 1'b0;
        #1;
    endtask

    // Kind 0 async exit, 1 exiting-event done, other instruction boundary
    task automatic pulse(input int w);
        @(posedge clk_i);
        case (w)
            0: async_exit_i <= 1'b1;
            1: eee_done_i <= 1'b1;
            default: insn_boundary_i <= 1'b1;
        endcase
        @(posedge clk_i);
        async_exit_i <= 1'b0;
        eee_done_i <= 1'b0;
        insn_boundary_i <= 1'b0;
        #1;
    endtask

    task automatic smp(input logic [63:0] ip);
        chk("sample_req", {63'h0, sample_req_o}, 64'h1);
        chk("eventing_ip", eventing_ip_o, ip);
    endtask

    task automatic wait_deliver;
        int n;
        n = 0;
        while (eee_deliver_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("eee_deliver", {63'h0, eee_deliver_o}, 64'h1);
    endtask

    task automatic regs_test;
        apb(1'b0, OFF_STATUS_HI, 32'h0);
        chk("flag at reset", {32'h0, rd}, 64'h0);
        apb(1'b1, OFF_CTR_EN, 32'h7F);
        apb(1'b1, OFF_MISC, 32'h3);
        apb(1'b0, OFF_CTR_EN, 32'h0);
        chk("ctr_en", {32'h0, rd}, 64'h7F);
        apb(1'b0, 8'hF0, 32'h0);
        chk("unmapped err", {63'h0, err}, 64'h1);
        apb(1'b1, 8'hF0, 32'h0);
        chk("unmapped wr err", {63'h0, err}, 64'h1);
        chk("count_en idle", {57'h0, count_en_o}, 64'h7F);
    endtask

    task automatic leaves_test;
        for (int i = 0; i < 3; i++) begin
            leaf(leaf_kind_t'(i), 64'h5000 + 64'(i * 16), 1'b0);
            smp(64'h5000 + 64'(i * 16));
        end
        sample_pending_i <= 1'b0;
        leaf(LEAF_SUPERVISOR, 64'h5100, 1'b0);
        chk("sample not pending", {63'h0, sample_req_o}, 64'h0);
        sample_pending_i <= 1'b1;
    endtask

    task automatic opt_in_test;
        b0 = branch_cnt;
        i0 = insn_cnt;
        leaf(LEAF_ENTER, 64'h1000, 1'b0);
        smp(64'h1000);
        @(posedge clk_i);
        #1;
        chk("count_en opt-in", {57'h0, count_en_o}, 64'h7F);
        apb(1'b0, OFF_STATUS_HI, 32'h0);
        chk("flag opt-in", {32'h0, rd}, 64'h0);
        leaf(LEAF_EXIT, 64'h1040, 1'b0);
        smp(64'h1040);
        @(posedge clk_i);
        #1;
        chk("branch opt-in", 64'(branch_cnt - b0), 64'h2);
        chk("insn opt-in", 64'(insn_cnt - i0), 64'h2);
    endtask

    task automatic opt_out_test;
        b0 = branch_cnt;
        i0 = insn_cnt;
        leaf(LEAF_ENTER, 64'h2000, 1'b1);
        chk("sample opt-out entry", {63'h0, sample_req_o}, 64'h0);
        @(posedge clk_i);
        #1;
        chk("count_en opt-out", {57'h0, count_en_o}, 64'(7'h7F & ~SUPPRESS_MASK));
        chk("demote", {63'h0, demote_sibling_o}, 64'h1);
        chk("shared", {63'h0, shared_count_en_o}, 64'h1);
        apb(1'b0, OFF_STATUS_HI, 32'h0);
        chk("flag opt-out", {32'h0, rd}, 64'h1000_0000);
        apb(1'b0, OFF_ENTRY_IP_LO, 32'h0);
        chk("entry ip", {32'h0, rd}, 64'h2000);
        leaf(LEAF_SUPERVISOR, 64'h2100, 1'b0);
        chk("sample inside", {63'h0, sample_req_o}, 64'h0);
        leaf(LEAF_EXIT, 64'h2200, 1'b0);
        smp(64'h2000);
        @(posedge clk_i);
        #1;
        chk("count_en exit", {57'h0, count_en_o}, 64'h7F);
        chk("demote exit", {63'h0, demote_sibling_o}, 64'h0);
        chk("branch opt-out", 64'(branch_cnt - b0), 64'h1);
        chk("insn opt-out", 64'(insn_cnt - i0), 64'h1);
        apb(1'b1, OFF_STATUS_HI, 32'h1000_0000);
        apb(1'b0, OFF_STATUS_HI, 32'h0);
        chk("flag cleared", {32'h0, rd}, 64'h0);
    endtask

    task automatic aex_fault_test;
        leaf(LEAF_ENTER, 64'h3000, 1'b0);
        t0 = n_abort;
        mode <= 2'h2;
        pulse(0);
        smp(64'hA000);
        wait_deliver();
        chk("abort count", 64'(n_abort - t0), 64'h1);
        mode <= 2'h0;
        pulse(1);
        smp(64'hB000);
    endtask

    task automatic aex_trap_test;
        leaf(LEAF_RESUME, 64'h4000, 1'b1);
        t0 = n_abort;
        mode <= 2'h3;
        pulse(0);
        smp(64'h4000);
        wait_deliver();
        chk("no abort", 64'(n_abort - t0), 64'h0);
        mode <= 2'h0;
        t0 = n_trap;
        repeat (3) @(posedge clk_i);
        #1;
        chk("trap held", 64'(n_trap - t0), 64'h0);
        pulse(2);
        repeat (2) @(posedge clk_i);
        #1;
        chk("trap serviced", 64'(n_trap - t0), 64'h1);
        chk("count_en after aex", {57'h0, count_en_o}, 64'h7F);
    endtask

    task automatic sibling_test;
        apb(1'b1, OFF_ALL_THREAD, 32'h7F);
        sibling_opt_out_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("all_thread demoted", {57'h0, all_thread_o}, 64'h0);
        @(posedge clk_i);
        sibling_opt_out_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("all_thread restored", {57'h0, all_thread_o}, 64'h7F);
    endtask

    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset for three cycles, then the scenarios in turn
    initial begin
        {clk_i, rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {leaf_retire_i, opt_out_entry_i, async_exit_i, eee_done_i, insn_boundary_i} = '0;
        {leaf_ip_i, sibling_opt_out_i, mode} = '0;
        leaf_kind_i = LEAF_OTHER_USER;
        sample_pending_i = 1'b1;
        saved_state_ip_i = 64'hA000;
        landing_ip_i = 64'hB000;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        regs_test();
        leaves_test();
        opt_in_test();
        opt_out_test();
        aex_fault_test();
        aex_trap_test();
        sibling_test();
        complete_run();
    end
endmodule
